//--- dmsp_pkg.sv
// Constants and types for the dual mode serial port
// Functional notes
// RL1: Async character: 7/8 data, parity, extra bit
// RL2: Receiver checks parity, captures extra bit
// RL3: Async full duplex; clocked half or full
// RL4: One byte buffer per direction
// RL5: Received byte readable after final sample
// RL6: Status shows rx, overrun, parity, tx
// RL7: Status updates at last bit in/out
// RL8: Interrupt on tx empty or rx full
// RL9: Four SPI modes, MSB or LSB first
// RL10: Infrared pulses 3/16 or 1/8 bit
// RL11: Clocked transfer may wait for match
// RL12: Async bit rate is clock/8 or /16
// RL13: Clocked mode: one bit per clock
// RL14: Own 8-bit prescaler per port
// RL15: Bootstrap async timing from 32 kHz
// RL16: Remote drives clock for clocked bootstrap
// RL17: Break: keep assembling or inhibit, configurable
// RL18: Async or clocked, internal or external clock
// RL19: Clocked transfers started by software
// RL20: Divisor equals prescale value plus one
// RL21: Address write appends 1, long-stop 0
// RL22: Control 10/11 or address write starts; code also starts on control 01
// RL23: Overrun when unread byte is replaced
package dmsp_pkg;
	// *****************************
	// Register indices (byte = 4*idx)
	// *****************************
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_ADDRBIT = 3'h1;
	localparam logic [2:0] IDX_LONGSTOP = 3'h2;
	localparam logic [2:0] IDX_STATUS = 3'h3;
	localparam logic [2:0] IDX_CONTROL = 3'h4;
	localparam logic [2:0] IDX_EXT = 3'h5;
	localparam logic [2:0] IDX_PRESCALE = 3'h6;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] EXT_RESET = 8'h00;
	localparam logic [7:0] PRESC_RESET = 8'h00;
	// Status bit positions
	localparam int ST_RX_AVAIL = 7;
	localparam int ST_RX_EXTRA = 6;
	localparam int ST_OVERRUN = 5;
	localparam int ST_PARITY = 4;
	localparam int ST_TX_FULL = 3;
	localparam int ST_TX_BUSY = 2;
	// Control codes
	localparam logic [1:0] CMD_RX = 2'h1;
	localparam logic [1:0] CMD_TX = 2'h2;
	localparam logic [1:0] CMD_TXRX = 2'h3;
	localparam logic [1:0] MODE_ASYNC8 = 2'h0;
	localparam logic [1:0] MODE_ASYNC7 = 2'h1;
	localparam logic [1:0] MODE_CLK_INT = 2'h2;
	localparam logic [1:0] MODE_CLK_EXT = 2'h3;
	localparam logic ADDR_BIT = 1'b1;
	localparam logic LONGSTOP_BIT = 1'b0;
	// *****************************
	// Timing
	// *****************************
	localparam logic [3:0] OS16_MAX = 4'hF;
	localparam logic [3:0] OS8_MAX = 4'h7;
	localparam logic [3:0] IR16_LEN = 4'h3;
	localparam logic [3:0] IR8_LEN = 4'h1;
	localparam int CLK32_HZ = 32768;
	localparam int BOOT_BPS = 2400;
	localparam int BOOT_OS = CLK32_HZ / BOOT_BPS;
	localparam logic [3:0] BOOT_OS_MAX = 4'(BOOT_OS - 1);
	localparam logic [3:0] BITS_LAST8 = 4'h7;
	localparam logic [3:0] BITS_LAST7 = 4'h6;
	localparam logic [3:0] CK_BITS = 4'h8;
	// *****************************
	// Types
	// *****************************
	typedef struct packed {
		logic [1:0] cmd;
		logic [1:0] mode;
		logic match_sync;
		logic [1:0] rsvd;
		logic rx_extra;
	} dmsp_ctrl_t;
	typedef struct packed {
		logic par_en;
		logic par_odd;
		logic msb_first;
		logic ir_pulse_encoding;
		logic brk_inhibit;
		logic div8;
		logic cpol;
		logic cpha;
	} dmsp_ext_t;
	typedef struct packed {
		logic txd;
		logic sclk_o;
		logic sclk_oe;
	} dmsp_pins_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
		TX_EXTRA, TX_STOP} dmsp_tx_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
		RX_EXTRA, RX_STOP, RX_BRK} dmsp_rx_t;
	typedef enum logic [1:0] {CK_IDLE, CK_ARM, CK_RUN} dmsp_ck_t;
endpackage

//--- dmsp_port.sv
// Dual mode serial port with APB register access
`timescale 1ns/1ps
module dmsp_port (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	input wire logic sclk_i,
	input wire logic match_evt,
	input wire logic boot_async,
	input wire logic clk32_tick,
	output dmsp_pkg::dmsp_pins_t pins,
	output logic irq_req
);
	// *****************************
	// Declarations
	// *****************************
	dmsp_pkg::dmsp_ctrl_t ctrl;
	dmsp_pkg::dmsp_ext_t ext;
	dmsp_pkg::dmsp_tx_t tx_st;
	dmsp_pkg::dmsp_rx_t rx_st;
	dmsp_pkg::dmsp_ck_t ck_st;
	logic [7:0] presc, pcnt;
	logic [7:0] tx_buf, tx_sh, rx_buf, rx_sh, ck_sh, next_ck_sh, rx_byte;
	logic tx_full, tx_hasx_buf, tx_xval_buf, tx_irq;
	logic rx_avail, rx_extra_bit, rx_over, rx_perr;
	logic tx_line, tx_par, tx_hasx, tx_x, rx_par, rx_x;
	logic [3:0] tx_os, rx_os, tx_cnt, rx_cnt, ck_cnt, os_max, rx_target;
	logic [3:0] bits_last, ir_len;
	logic ck_do_tx, ck_do_rx, ck_out, sclk_r, sclk_prev;
	logic [2:0] idx;
	logic mapped, wr, setup_rd, data_rd, any_tx_wr;
	logic clocked, ext_clk, n7, dtick, half_tick, ostick;
	logic a_take, ck_take, tx_take, a_done, a_perr, ck_rx_done, rx_done;
	logic rx_done_perr, rx_done_x, a_drop, ck_start, ck_go;
	logic lead, trail, sample_ev, out_ev, ck_done, txd_async;
	logic [7:0] a_byte;

	function automatic logic hit(input logic en, input logic [2:0] i,
		input logic [2:0] target);
		return en && (i == target);
	endfunction

	function automatic logic par_of(input logic [7:0] d, input logic short7,
		input logic odd);
		return (^(short7 ? {1'b0, d[6:0]} : d)) ^ odd;
	endfunction

	// *****************************
	// APB slave
	// *****************************
	assign idx = paddr[4:2];
	assign mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0)
		&& (idx <= dmsp_pkg::IDX_PRESCALE);
	assign wr = psel && penable && pwrite && mapped;
	assign setup_rd = psel && !penable && !pwrite;
	assign data_rd = hit(psel && penable && !pwrite && mapped, idx,
		dmsp_pkg::IDX_DATA);
	assign any_tx_wr = hit(wr, idx, dmsp_pkg::IDX_DATA)
		|| hit(wr, idx, dmsp_pkg::IDX_ADDRBIT)
		|| hit(wr, idx, dmsp_pkg::IDX_LONGSTOP);
	// Zero wait states keep every access at two cycles
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup_rd && !mapped)
			prdata <= 32'h0000_0000;
		else if (setup_rd)
		begin
			prdata <= 32'h0000_0000;
			unique case (idx)
				dmsp_pkg::IDX_DATA: prdata[7:0] <= rx_buf;
				dmsp_pkg::IDX_STATUS:
				begin
					prdata[dmsp_pkg::ST_RX_AVAIL] <= rx_avail; // RL6
					prdata[dmsp_pkg::ST_RX_EXTRA] <= rx_extra_bit;
					prdata[dmsp_pkg::ST_OVERRUN] <= rx_over;
					prdata[dmsp_pkg::ST_PARITY] <= rx_perr;
					prdata[dmsp_pkg::ST_TX_FULL] <= tx_full;
					prdata[dmsp_pkg::ST_TX_BUSY] <= (tx_st != dmsp_pkg::TX_IDLE)
						|| (ck_st == dmsp_pkg::CK_RUN && ck_do_tx);
				end
				dmsp_pkg::IDX_CONTROL: prdata[5:0] <= ctrl[5:0];
				dmsp_pkg::IDX_EXT: prdata[7:0] <= ext;
				dmsp_pkg::IDX_PRESCALE: prdata[7:0] <= presc;
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// *****************************
	// Configuration registers
	// *****************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= dmsp_pkg::CTRL_RESET;
			ext <= dmsp_pkg::EXT_RESET;
			presc <= dmsp_pkg::PRESC_RESET;
		end
		else
		begin
			// Command field acts on write only, never stored
			if (hit(wr, idx, dmsp_pkg::IDX_CONTROL))
				ctrl <= {2'b00, pwdata[5:0]}; // RL18
			if (hit(wr, idx, dmsp_pkg::IDX_EXT))
				ext <= pwdata[7:0];
			if (hit(wr, idx, dmsp_pkg::IDX_PRESCALE))
				presc <= pwdata[7:0];
		end
	end

	// Bootstrap forces 8-bit asynchronous operation
	assign clocked = !boot_async && ctrl.mode[1]; // RL18
	assign ext_clk = ctrl.mode == dmsp_pkg::MODE_CLK_EXT;
	assign n7 = !boot_async && (ctrl.mode == dmsp_pkg::MODE_ASYNC7); // RL1
	assign bits_last = n7 ? dmsp_pkg::BITS_LAST7 : dmsp_pkg::BITS_LAST8;

	// *****************************
	// Data clock prescaler
	// *****************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pcnt <= 8'h00;
		else if (dtick)
			pcnt <= 8'h00;
		else
			pcnt <= pcnt + 8'h01;
	end
	assign dtick = pcnt == presc; // RL14 RL20
	assign half_tick = pcnt == {1'b0, presc[7:1]};
	assign ostick = boot_async ? clk32_tick : dtick; // RL15
	assign os_max = boot_async ? dmsp_pkg::BOOT_OS_MAX
		: ext.div8 ? dmsp_pkg::OS8_MAX : dmsp_pkg::OS16_MAX; // RL12
	assign ir_len = ext.div8 ? dmsp_pkg::IR8_LEN : dmsp_pkg::IR16_LEN;

	// *****************************
	// Transmit buffer and flags
	// *****************************
	// Start on a tick so the start bit and its pulse are full width
	assign a_take = !clocked && tx_st == dmsp_pkg::TX_IDLE && tx_full
		&& ostick;
	assign tx_take = a_take || ck_take;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_buf <= 8'h00;
			tx_full <= 1'b0;
			tx_hasx_buf <= 1'b0;
			tx_xval_buf <= 1'b0;
			tx_irq <= 1'b0;
		end
		else
		begin
			if (any_tx_wr) // RL4
			begin
				tx_buf <= pwdata[7:0];
				tx_hasx_buf <= !hit(wr, idx, dmsp_pkg::IDX_DATA);
				tx_xval_buf <= hit(wr, idx, dmsp_pkg::IDX_ADDRBIT)
					? dmsp_pkg::ADDR_BIT : dmsp_pkg::LONGSTOP_BIT; // RL21
			end
			if (any_tx_wr)
				tx_full <= 1'b1;
			else if (tx_take)
				tx_full <= 1'b0;
			// Emptying wins over the clearing write
			if (tx_take)
				tx_irq <= 1'b1; // RL8
			else if (any_tx_wr)
				tx_irq <= 1'b0;
		end
	end

	// *****************************
	// Receive buffer and flags
	// *****************************
	assign rx_done = a_done || ck_rx_done;
	assign rx_done_perr = a_done && a_perr;
	assign rx_done_x = a_done && rx_x;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_buf <= 8'h00;
			rx_avail <= 1'b0;
			rx_over <= 1'b0;
			rx_perr <= 1'b0;
			rx_extra_bit <= 1'b0;
		end
		else if (rx_done) // RL5 RL7
		begin
			rx_buf <= rx_byte;
			rx_avail <= 1'b1;
			rx_over <= rx_over || (rx_avail && !data_rd); // RL23
			rx_perr <= rx_done_perr; // RL2
			rx_extra_bit <= rx_done_x;
		end
		else if (data_rd)
		begin
			rx_avail <= 1'b0;
			rx_over <= 1'b0;
			rx_perr <= 1'b0;
		end
	end
	assign rx_byte = a_done ? a_byte : (ck_do_tx || ck_do_rx) ? next_ck_sh
		: ck_sh;
	assign irq_req = rx_avail || tx_irq; // RL8

	// *****************************
	// Asynchronous transmitter
	// *****************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_st <= dmsp_pkg::TX_IDLE;
			tx_os <= 4'h0;
			tx_cnt <= 4'h0;
			tx_sh <= 8'h00;
			tx_line <= 1'b1;
			tx_par <= 1'b0;
			tx_hasx <= 1'b0;
			tx_x <= 1'b0;
		end
		else if (clocked)
		begin
			tx_st <= dmsp_pkg::TX_IDLE;
			tx_line <= 1'b1;
		end
		else if (tx_st == dmsp_pkg::TX_IDLE)
		begin
			if (tx_full && ostick) // RL3
			begin
				tx_st <= dmsp_pkg::TX_START;
				tx_sh <= tx_buf;
				tx_hasx <= tx_hasx_buf;
				tx_x <= tx_xval_buf;
				tx_par <= par_of(tx_buf, n7, ext.par_odd);
				tx_line <= 1'b0;
				tx_os <= 4'h0;
				tx_cnt <= 4'h0;
			end
		end
		else if (ostick && tx_os != os_max)
			tx_os <= tx_os + 4'h1;
		else if (ostick)
		begin
			tx_os <= 4'h0;
			unique case (tx_st)
				dmsp_pkg::TX_START:
				begin
					tx_st <= dmsp_pkg::TX_DATA;
					tx_line <= tx_sh[0];
				end
				dmsp_pkg::TX_DATA:
				begin
					tx_sh <= {1'b0, tx_sh[7:1]};
					tx_cnt <= tx_cnt + 4'h1;
					if (tx_cnt != bits_last)
						tx_line <= tx_sh[1];
					else if (ext.par_en) // RL1
					begin
						tx_st <= dmsp_pkg::TX_PAR;
						tx_line <= tx_par;
					end
					else if (tx_hasx)
					begin
						tx_st <= dmsp_pkg::TX_EXTRA;
						tx_line <= tx_x;
					end
					else
					begin
						tx_st <= dmsp_pkg::TX_STOP;
						tx_line <= 1'b1;
					end
				end
				dmsp_pkg::TX_PAR:
				begin
					tx_st <= tx_hasx ? dmsp_pkg::TX_EXTRA : dmsp_pkg::TX_STOP;
					tx_line <= tx_hasx ? tx_x : 1'b1;
				end
				dmsp_pkg::TX_EXTRA:
				begin
					tx_st <= dmsp_pkg::TX_STOP;
					tx_line <= 1'b1;
				end
				default:
				begin
					tx_st <= dmsp_pkg::TX_IDLE; // RL7
					tx_line <= 1'b1;
				end
			endcase
		end
	end

	// Infrared: a zero bit is a short high pulse, idle stays low
	assign txd_async = ext.ir_pulse_encoding
		? (tx_st != dmsp_pkg::TX_IDLE && !tx_line && tx_os < ir_len)
		: tx_line; // RL10

	// *****************************
	// Asynchronous receiver
	// *****************************
	assign rx_target = rx_st == dmsp_pkg::RX_START
		? {1'b0, os_max[3:1]} : os_max;
	assign a_byte = n7 ? {1'b0, rx_sh[7:1]} : rx_sh;
	assign a_perr = ext.par_en
		&& (par_of(a_byte, n7, ext.par_odd) != rx_par); // RL2
	// Break: all-zero character with a zero stop bit
	assign a_drop = !rxd && a_byte == 8'h00 && ext.brk_inhibit; // RL17
	assign a_done = !clocked && rx_st == dmsp_pkg::RX_STOP && ostick
		&& rx_os == rx_target && !a_drop;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_st <= dmsp_pkg::RX_IDLE;
			rx_os <= 4'h0;
			rx_cnt <= 4'h0;
			rx_sh <= 8'h00;
			rx_par <= 1'b0;
			rx_x <= 1'b0;
		end
		else if (clocked)
			rx_st <= dmsp_pkg::RX_IDLE;
		else if (rx_st == dmsp_pkg::RX_IDLE)
		begin
			if (!rxd)
			begin
				rx_st <= dmsp_pkg::RX_START;
				rx_os <= 4'h0;
				rx_x <= 1'b0;
			end
		end
		else if (rx_st == dmsp_pkg::RX_BRK)
		begin
			if (rxd)
				rx_st <= dmsp_pkg::RX_IDLE;
		end
		else if (ostick && rx_os != rx_target)
			rx_os <= rx_os + 4'h1;
		else if (ostick)
		begin
			rx_os <= 4'h0;
			unique case (rx_st)
				dmsp_pkg::RX_START:
				begin
					rx_st <= rxd ? dmsp_pkg::RX_IDLE : dmsp_pkg::RX_DATA;
					rx_cnt <= 4'h0;
				end
				dmsp_pkg::RX_DATA:
				begin
					rx_sh <= {rxd, rx_sh[7:1]};
					rx_cnt <= rx_cnt + 4'h1;
					if (rx_cnt == bits_last)
						rx_st <= ext.par_en ? dmsp_pkg::RX_PAR
							: ctrl.rx_extra ? dmsp_pkg::RX_EXTRA
							: dmsp_pkg::RX_STOP;
				end
				dmsp_pkg::RX_PAR:
				begin
					rx_par <= rxd;
					rx_st <= ctrl.rx_extra ? dmsp_pkg::RX_EXTRA
						: dmsp_pkg::RX_STOP;
				end
				dmsp_pkg::RX_EXTRA:
				begin
					rx_x <= rxd; // RL2
					rx_st <= dmsp_pkg::RX_STOP;
				end
				// Without inhibit a held-low line restarts at once
				default: rx_st <= a_drop ? dmsp_pkg::RX_BRK
					: dmsp_pkg::RX_IDLE; // RL17
			endcase
		end
	end

	// *****************************
	// Clocked engine
	// *****************************
	assign ck_start = clocked && (hit(wr, idx, dmsp_pkg::IDX_ADDRBIT)
		|| (hit(wr, idx, dmsp_pkg::IDX_CONTROL) && pwdata[7:6] != 2'h0));
	assign ck_go = (!ctrl.match_sync || match_evt) // RL11
		&& (!ck_do_tx || tx_full);
	assign ck_take = ck_st == dmsp_pkg::CK_ARM && ck_go && ck_do_tx;
	always_comb
	begin
		lead = 1'b0;
		trail = 1'b0;
		if (ck_st == dmsp_pkg::CK_RUN)
		begin
			if (ext_clk) // RL16
			begin
				lead = sclk_i != sclk_prev && sclk_i != ext.cpol;
				trail = sclk_i != sclk_prev && sclk_i == ext.cpol;
			end
			else // RL13
			begin
				lead = (dtick || half_tick) && sclk_r == ext.cpol;
				trail = (dtick || half_tick) && sclk_r != ext.cpol;
			end
		end
	end
	assign sample_ev = ext.cpha ? trail : lead; // RL9
	assign out_ev = ext.cpha ? lead : trail;
	assign next_ck_sh = !sample_ev ? ck_sh : ext.msb_first
		? {ck_sh[6:0], rxd} : {rxd, ck_sh[7:1]};
	assign ck_done = trail
		&& (ck_cnt + {3'h0, sample_ev}) == dmsp_pkg::CK_BITS;
	assign ck_rx_done = ck_done && ck_do_rx;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sclk_prev <= 1'b0;
		else
			sclk_prev <= sclk_i;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ck_st <= dmsp_pkg::CK_IDLE;
			ck_do_tx <= 1'b0;
			ck_do_rx <= 1'b0;
			ck_sh <= 8'h00;
			ck_cnt <= 4'h0;
			ck_out <= 1'b1;
			sclk_r <= 1'b0;
		end
		else if (!clocked)
		begin
			ck_st <= dmsp_pkg::CK_IDLE;
			sclk_r <= ext.cpol;
		end
		else
		begin
			unique case (ck_st)
				dmsp_pkg::CK_IDLE:
				begin
					sclk_r <= ext.cpol;
					if (ck_start) // RL19 RL22
					begin
						ck_st <= dmsp_pkg::CK_ARM;
						ck_do_tx <= hit(wr, idx, dmsp_pkg::IDX_ADDRBIT)
							|| pwdata[7];
						ck_do_rx <= !hit(wr, idx, dmsp_pkg::IDX_ADDRBIT)
							&& pwdata[6]; // RL3
					end
				end
				dmsp_pkg::CK_ARM:
				begin
					if (ck_go)
					begin
						ck_st <= dmsp_pkg::CK_RUN;
						ck_cnt <= 4'h0;
						ck_sh <= ck_do_tx ? tx_buf : 8'hFF;
						ck_out <= !ck_do_tx || (ext.msb_first ? tx_buf[7]
							: tx_buf[0]);
					end
				end
				default:
				begin
					if (lead || trail)
						sclk_r <= lead ? !ext.cpol : ext.cpol;
					ck_sh <= next_ck_sh;
					if (sample_ev)
						ck_cnt <= ck_cnt + 4'h1;
					if (out_ev)
						ck_out <= ext.msb_first ? next_ck_sh[7] : next_ck_sh[0];
					if (ck_done)
						ck_st <= dmsp_pkg::CK_IDLE;
				end
			endcase
		end
	end

	// *****************************
	// Pin outputs
	// *****************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pins <= 3'b100;
		else
		begin
			pins.txd <= clocked ? ck_out : txd_async;
			pins.sclk_o <= sclk_r;
			pins.sclk_oe <= clocked && !ext_clk; // RL18
		end
	end
endmodule

//--- dmsp_port_sva.sv
// Bus and line-pin assertions for the serial port
`timescale 1ns/1ps
module dmsp_port_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire dmsp_pkg::dmsp_pins_t pins
);
	logic acc;
	logic bad_a;
	logic [7:0] ext_q;
	logic [7:0] pre_q;
	logic clk_m;
	logic clk_m_d;
	logic txd_d;
	logic [11:0] hi_cnt;
	logic [11:0] ir_len;
	assign bad_a = paddr[4:2] == 3'h7 || paddr[1:0] != 2'h0
		|| paddr[7:5] != 3'h0;
	assign acc = psel && penable && pwrite && !bad_a;
	assign ir_len = ({4'h0, pre_q} + 12'h001)
		* (ext_q[2] ? 12'h001 : 12'h003);
	// ****************
	// Shadow settings
	// ****************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_q <= 8'h00;
			pre_q <= 8'h00;
			clk_m <= 1'h0;
			clk_m_d <= 1'h0;
		end
		else
		begin
			clk_m_d <= clk_m;
			if (acc && paddr[4:2] == dmsp_pkg::IDX_EXT)
				ext_q <= pwdata[7:0];
			if (acc && paddr[4:2] == dmsp_pkg::IDX_PRESCALE)
				pre_q <= pwdata[7:0];
			if (acc && paddr[4:2] == dmsp_pkg::IDX_CONTROL)
				clk_m <= pwdata[5];
		end
	end
	// A level already high when IR is enabled is not a pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hi_cnt <= 12'h000;
			txd_d <= 1'h1;
		end
		else
		begin
			txd_d <= pins.txd;
			if (!ext_q[4] || !pins.txd)
				hi_cnt <= 12'h000;
			else if (!txd_d)
				hi_cnt <= 12'h001;
			else if (hi_cnt != 12'h000)
				hi_cnt <= hi_cnt + 12'h001;
		end
	end
	// ****************
	// Properties
	// ****************
	default clocking dcb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_high: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	a_err_unmap: assert property (psel && penable && bad_a |->
		pslverr && (pwrite || prdata == 32'h00000000))
		else $error("unmapped access not refused");
	a_err_none: assert property (!(psel && penable && bad_a) |->
		!pslverr)
		else $error("pslverr without unmapped access");
	a_rdata_byte: assert property (psel && penable && !pwrite |->
		prdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_txd_reset: assert property ($rose(presetn) |->
		pins.txd && !pins.sclk_oe)
		else $error("line pins not idle after reset");
	a_oe_async: assert property (!clk_m && !clk_m_d |->
		!pins.sclk_oe)
		else $error("clock output enabled outside clocked mode");
	a_sclk_rest: assert property (!clk_m && !clk_m_d &&
		!$past(clk_m_d) && ext_q == $past(ext_q, 2) |->
		pins.sclk_o == ext_q[1])
		else $error("idle clock not at polarity");
	a_ir_len: assert property (ext_q[4] && $fell(pins.txd) &&
		hi_cnt != 12'h000 |-> hi_cnt == ir_len)
		else $error("infrared pulse length wrong");
	a_ir_bound: assert property (ext_q[4] && hi_cnt != 12'h000 |->
		hi_cnt <= ir_len)
		else $error("infrared pulse too long");
	c_unmapped: cover property (psel && penable && bad_a);
	c_ir_pulse: cover property (ext_q[4] && $fell(pins.txd));
	c_tx_start: cover property (!ext_q[4] && $fell(pins.txd));
endmodule
bind dmsp_port dmsp_port_sva u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pins(pins));

//--- dmsp_remote.sv
// Remote serial device, asynchronous and clocked, facing the port's line pins
`timescale 1ns/1ps
module dmsp_remote (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out,
	output logic sclk_out,
	input wire logic [15:0] bit_cyc,
	input wire logic want_extra
);
	logic [7:0] got_byte;
	logic got_extra;
	int got_count;
	initial
	begin
		line_out = 1'h1;
		sclk_out = 1'h0;
		got_byte = 8'h00;
		got_extra = 1'h0;
		got_count = 0;
	end
	// Mid-bit sampling, LSB first; the stop bit is not judged
	always
	begin
		@(negedge line_in);
		repeat (bit_cyc / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (bit_cyc) @(posedge clk);
			got_byte[i] = line_in;
		end
		if (want_extra)
		begin
			repeat (bit_cyc) @(posedge clk);
			got_extra = line_in;
		end
		repeat (bit_cyc) @(posedge clk);
		got_count++;
	end
	task automatic send(input logic [7:0] b, input logic par_on,
		input logic par);
		@(posedge clk);
		line_out <= 1'h0;
		repeat (bit_cyc) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			line_out <= b[i];
			repeat (bit_cyc) @(posedge clk);
		end
		if (par_on)
		begin
			line_out <= par;
			repeat (bit_cyc) @(posedge clk);
		end
		line_out <= 1'h1;
		repeat (bit_cyc) @(posedge clk);
	endtask
	// The peer owns the bit clock; MSB first, idle low, sample on rise
	task automatic clk_send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			line_out <= b[i];
			repeat (4) @(posedge clk);
			sclk_out <= 1'h1;
			repeat (4) @(posedge clk);
			sclk_out <= 1'h0;
		end
		repeat (4) @(posedge clk);
		line_out <= 1'h1;
	endtask
endmodule

//--- dual_mode_serial_port_tb.sv
// Self-checking bench for the dual mode serial port
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		tests_run++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("Error at %0t: got %h exp %h", $time, g, e); \
		end \
	end
module dual_mode_serial_port_tb;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rxd;
	logic irq_req;
	dmsp_pkg::dmsp_pins_t pins;
	logic [15:0] bit_cyc;
	logic want_extra;
	logic sclk_ext;
	logic match_evt;
	logic [31:0] rd;
	logic er;
	int bad_count;
	int tests_run;
	initial
		pclk = 1'h0;
	always
		#25 pclk = ~pclk;
	// Bootstrap path is left idle
	dmsp_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .sclk_i(sclk_ext),
		.match_evt(match_evt),
		.boot_async(1'h0), .clk32_tick(1'h0), .pins(pins),
		.irq_req(irq_req));
	dmsp_remote u_remote (.clk(pclk), .line_in(pins.txd),
		.line_out(rxd), .sclk_out(sclk_ext), .bit_cyc(bit_cyc),
		.want_extra(want_extra));
	// ****************
	// Shared tasks
	// ****************
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic give_up();
		bad_count++;
		tally_and_finish();
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1)
			give_up();
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wait_heard(input int cnt);
		for (int n = 0; n < 2000 && u_remote.got_count < cnt; n++)
			@(posedge pclk);
		if (u_remote.got_count < cnt)
			give_up();
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_reset_map();
		apb(1'h0, 8'h0C, 8'h00);
		`CHK(rd, 32'h00000000)
		apb(1'h0, 8'h14, 8'h00);
		`CHK(rd, 32'h00000000)
		apb(1'h0, 8'h1C, 8'h00);
		`CHK({er, rd}, {1'h1, 32'h00000000})
		apb(1'h1, 8'h18, 8'h01);
		apb(1'h0, 8'h18, 8'h00);
		`CHK(rd, 32'h00000001)
	endtask
	task automatic t_tx_frames();
		apb(1'h1, 8'h00, 8'hA5);
		apb(1'h1, 8'h00, 8'h5A);
		apb(1'h0, 8'h0C, 8'h00);
		`CHK(rd[3:2], 2'h3)
		wait_heard(1);
		`CHK(u_remote.got_byte, 8'hA5)
		wait_heard(2);
		`CHK(u_remote.got_byte, 8'h5A)
		repeat (32) @(posedge pclk);
		apb(1'h0, 8'h0C, 8'h00);
		`CHK(rd[3:2], 2'h0)
		`CHK(irq_req, 1'h1)
		want_extra = 1'h1;
		for (int i = 0; i < 2; i++)
		begin
			apb(1'h1, i ? 8'h08 : 8'h04, 8'h3C);
			wait_heard(3 + i);
			`CHK({u_remote.got_extra, u_remote.got_byte}, {i == 0, 8'h3C})
			repeat (32) @(posedge pclk);
		end
		want_extra = 1'h0;
	endtask
	task automatic t_rx_flags();
		u_remote.send(8'h3C, 1'h0, 1'h0);
		apb(1'h0, 8'h0C, 8'h00);
		`CHK(rd[7:4], 4'h8)
		apb(1'h0, 8'h00, 8'h00);
		`CHK(rd, 32'h0000003C)
		apb(1'h0, 8'h0C, 8'h00);
		`CHK(rd[7], 1'h0)
		u_remote.send(8'h11, 1'h0, 1'h0);
		u_remote.send(8'h22, 1'h0, 1'h0);
		apb(1'h0, 8'h0C, 8'h00);
		`CHK(rd[7:4], 4'hA)
		apb(1'h0, 8'h00, 8'h00);
		`CHK(rd[7:0], 8'h22)
		apb(1'h1, 8'h14, 8'h80);
		u_remote.send(8'h07, 1'h1, 1'h0);
		apb(1'h0, 8'h0C, 8'h00);
		`CHK(rd[7:4], 4'h9)
		apb(1'h0, 8'h00, 8'h00);
		`CHK(rd[7:0], 8'h07)
		apb(1'h1, 8'h14, 8'h00);
	endtask
	task automatic t_ir_pulses();
		int rises;
		logic last;
		for (int k = 0; k < 2; k++)
		begin
			apb(1'h1, 8'h14, k ? 8'h14 : 8'h10);
			repeat (4) @(posedge pclk);
			apb(1'h1, 8'h00, 8'h00);
			rises = 0;
			last = pins.txd;
			repeat (400)
			begin
				@(posedge pclk);
				if (pins.txd === 1'h1 && last === 1'h0)
					rises++;
				last = pins.txd;
			end
			// Start bit plus eight zero data bits
			`CHK(rises, 9)
		end
	endtask
	task automatic t_clocked();
		logic [7:0] got;
		logic last;
		int edges;
		apb(1'h1, 8'h14, 8'h20);
		apb(1'h1, 8'h10, 8'h28);
		apb(1'h1, 8'h04, 8'hA7);
		repeat (8) @(posedge pclk);
		apb(1'h0, 8'h0C, 8'h00);
		`CHK(rd[3:2], 2'h2)
		match_evt <= 1'h1;
		@(posedge pclk);
		match_evt <= 1'h0;
		edges = 0;
		last = pins.sclk_o;
		for (int n = 0; n < 200 && edges < 8; n++)
		begin
			@(posedge pclk);
			if (pins.sclk_o === 1'h1 && last === 1'h0)
			begin
				got = {got[6:0], pins.txd};
				edges++;
			end
			last = pins.sclk_o;
		end
		`CHK({pins.sclk_oe, got}, {1'h1, 8'hA7})
		`CHK(edges, 8)
		apb(1'h1, 8'h10, 8'h30);
		apb(1'h1, 8'h10, 8'h70);
		u_remote.clk_send(8'h96);
		apb(1'h0, 8'h0C, 8'h00);
		`CHK(rd[7:4], 4'h8)
		apb(1'h0, 8'h00, 8'h00);
		`CHK(rd[7:0], 8'h96)
		apb(1'h1, 8'h10, 8'h00);
	endtask
	initial
	begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		bit_cyc = 16'h0020;
		match_evt = 1'h0;
		want_extra = 1'h0;
		bad_count = 0;
		tests_run = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		t_reset_map();
		t_tx_frames();
		t_rx_flags();
		t_clocked();
		t_ir_pulses();
		tally_and_finish();
	end
endmodule
